// File: rtl/ivps_defines.vh
// constants for the interrupt vector priority and stacking block
`ifndef IVPS_DEFINES_VH
`define IVPS_DEFINES_VH
`define IVPS_VEC_RESERVED  16'hFFD0
`define IVPS_VEC_TIMEBASE  16'hFFD2
`define IVPS_VEC_SP2_TX    16'hFFD4
`define IVPS_VEC_SP2_RX    16'hFFD6
`define IVPS_VEC_SP2_ERR   16'hFFD8
`define IVPS_VEC_SPI_TX    16'hFFDA
`define IVPS_VEC_SPI_RX    16'hFFDC
`define IVPS_VEC_ADC       16'hFFDE
`define IVPS_VEC_KBD       16'hFFE0
`define IVPS_VEC_SP1_TX    16'hFFE2
`define IVPS_VEC_SP1_RX    16'hFFE4
`define IVPS_VEC_SP1_ERR   16'hFFE6
`define IVPS_VEC_TWOWIRE   16'hFFE8
`define IVPS_VEC_T2_OVF    16'hFFEA
`define IVPS_VEC_T2_CH1    16'hFFEC
`define IVPS_VEC_T2_CH0    16'hFFEE
`define IVPS_VEC_T1_OVF    16'hFFF0
`define IVPS_VEC_T1_CH1    16'hFFF2
`define IVPS_VEC_T1_CH0    16'hFFF4
`define IVPS_VEC_PLL       16'hFFF6
`define IVPS_VEC_EXT2      16'hFFF8
`define IVPS_VEC_EXT1      16'hFFFA
`define IVPS_VEC_SWI       16'hFFFC
`define IVPS_VEC_RESET     16'hFFFE
`define IVPS_SP_RESET      16'h00FF
`define IVPS_STACK_BYTES   3'h5
`define IVPS_NUM_FLAGS     21
`endif

// File: rtl/ivps_priority.v
// priority encoder from pending source flags to a vector address
`timescale 1ns/100ps
`include "ivps_defines.vh"
module ivps_priority (
    input  wire [21:1] i_pending,
    input  wire        i_swi,
    input  wire        i_reset_req,
    output reg  [15:0] o_vector,
    output reg         o_any
);
    // lower flag number sits higher in the table, so scan flags 21 down to 1
    function [15:0] ivps_flag_vec;
        input [4:0] n;
        begin
            case (n)
                5'h01:   ivps_flag_vec = `IVPS_VEC_EXT1;
                5'h02:   ivps_flag_vec = `IVPS_VEC_EXT2;
                5'h03:   ivps_flag_vec = `IVPS_VEC_PLL;
                5'h04:   ivps_flag_vec = `IVPS_VEC_T1_CH0;
                5'h05:   ivps_flag_vec = `IVPS_VEC_T1_CH1;
                5'h06:   ivps_flag_vec = `IVPS_VEC_T1_OVF;
                5'h07:   ivps_flag_vec = `IVPS_VEC_T2_CH0;
                5'h08:   ivps_flag_vec = `IVPS_VEC_T2_CH1;
                5'h09:   ivps_flag_vec = `IVPS_VEC_T2_OVF;
                5'h0A:   ivps_flag_vec = `IVPS_VEC_TWOWIRE;
                5'h0B:   ivps_flag_vec = `IVPS_VEC_SP1_ERR;
                5'h0C:   ivps_flag_vec = `IVPS_VEC_SP1_RX;
                5'h0D:   ivps_flag_vec = `IVPS_VEC_SP1_TX;
                5'h0E:   ivps_flag_vec = `IVPS_VEC_KBD;
                5'h0F:   ivps_flag_vec = `IVPS_VEC_ADC;
                5'h10:   ivps_flag_vec = `IVPS_VEC_SPI_RX;
                5'h11:   ivps_flag_vec = `IVPS_VEC_SPI_TX;
                5'h12:   ivps_flag_vec = `IVPS_VEC_SP2_ERR;
                5'h13:   ivps_flag_vec = `IVPS_VEC_SP2_RX;
                5'h14:   ivps_flag_vec = `IVPS_VEC_SP2_TX;
                5'h15:   ivps_flag_vec = `IVPS_VEC_TIMEBASE;
                default: ivps_flag_vec = `IVPS_VEC_RESERVED;
            endcase
        end
    endfunction

    integer k;
    always @* begin
        o_vector = `IVPS_VEC_RESERVED;
        o_any    = 1'b0;
        for (k = 21; k >= 1; k = k - 1) begin
            if (i_pending[k]) begin
                o_vector = ivps_flag_vec(k[4:0]);
                o_any    = 1'b1;
            end
        end
        if (i_swi) begin
            o_vector = `IVPS_VEC_SWI;
            o_any    = 1'b1;
        end
        if (i_reset_req) begin
            o_vector = `IVPS_VEC_RESET;
            o_any    = 1'b1;
        end
    end
endmodule // ivps_priority

// File: rtl/ivps_top.v
// interrupt vector selection, vector byte fetch and interrupt entry stacking
`timescale 1ns/100ps
`include "ivps_defines.vh"
module ivps_top (
    input  wire        i_clk_sys,
    input  wire        i_reset,
    input  wire        i_ce,
    input  wire [21:1] i_source_flag,
    input  wire [21:1] i_source_mask,
    input  wire        i_irq_enable,
    input  wire        i_software_interrupt,
    input  wire        i_take,
    input  wire [15:0] i_pc,
    input  wire [7:0]  i_acc,
    input  wire [7:0]  i_index_low,
    input  wire [7:0]  i_index_high,
    input  wire [7:0]  i_ccr,
    input  wire        i_sp_load,
    input  wire [15:0] i_sp_load_value,
    input  wire        i_push,
    input  wire        i_pull,
    output wire        o_irq_pending,
    output wire [15:0] o_vector_addr,
    output reg  [15:0] o_sp,
    output reg         o_mem_we,
    output reg  [15:0] o_mem_addr,
    output reg  [7:0]  o_mem_wdata,
    output reg         o_vec_rd,
    output reg  [15:0] o_vec_rd_addr,
    output reg         o_busy,
    output reg         o_done,
    output reg  [15:0] o_taken_vector
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_STACK = 2'h1;
    localparam ST_VECHI = 2'h2;
    localparam ST_VECLO = 2'h3;

    // one pointer step, shared by software push and pull and by entry stacking
    function [15:0] ivps_sp_step;
        input [15:0] sp;
        input        up;
        begin
            if (up) begin
                ivps_sp_step = sp + 16'h0001;
            end else begin
                ivps_sp_step = sp - 16'h0001;
            end
        end
    endfunction

    // byte address inside a two-byte vector: high byte even, low byte odd
    function [15:0] ivps_vec_byte;
        input [15:0] vec;
        input        low;
        begin
            ivps_vec_byte = {vec[15:1], low};
        end
    endfunction

    // five stacked bytes, the first one pushed in the top slot
    function [39:0] ivps_frame;
        input [15:0] pc;
        input [7:0]  index_low;
        input [7:0]  acc;
        input [7:0]  ccr;
        begin
            // index high stays out so frames match the older eight-bit family
            ivps_frame = {pc[7:0], pc[15:8], index_low, acc, ccr};
        end
    endfunction

    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [2:0]  cnt_reg;
    reg  [2:0]  cnt_next;
    reg  [15:0] vec_reg;
    reg  [15:0] vec_next;
    reg  [39:0] frame_reg;
    reg  [39:0] frame_next;
    reg  [15:0] sp_next;
    wire [15:0] sel_vec;
    wire        sel_any;
    wire        accept;
    wire        last_byte;
    wire [21:1] pending;

    // software interrupt is not gated by the global enable, flagged sources are
    assign pending   = i_source_flag & ~i_source_mask & {21{i_irq_enable}};
    assign accept    = (state_reg == ST_IDLE) && i_take && sel_any;
    assign last_byte = (cnt_reg == (`IVPS_STACK_BYTES - 3'h1));

    ivps_priority u_prio (
        .i_pending   (pending),
        .i_swi       (i_software_interrupt),
        .i_reset_req (1'b0),
        .o_vector    (sel_vec),
        .o_any       (sel_any)
    );

    assign o_irq_pending = sel_any;
    assign o_vector_addr = sel_vec;

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    state_next = ST_STACK;
                end
            end
            ST_STACK: begin
                if (last_byte) begin
                    state_next = ST_VECHI;
                end
            end
            ST_VECHI: begin
                state_next = ST_VECLO;
            end
            ST_VECLO: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // the vector is frozen at the take, so a later request cannot switch it mid-entry
    always @* begin
        cnt_next   = 3'h0;
        frame_next = frame_reg;
        vec_next   = vec_reg;
        if (state_reg == ST_STACK) begin
            cnt_next   = cnt_reg + 3'h1;
            frame_next = {frame_reg[31:0], 8'h00};
        end else if (accept) begin
            vec_next   = sel_vec;
            frame_next = ivps_frame(i_pc, i_index_low, i_acc, i_ccr);
        end
    end

    // take outranks a load, a load outranks push and pull; both together cancel
    always @* begin
        sp_next = o_sp;
        if (state_reg == ST_STACK) begin
            sp_next = ivps_sp_step(o_sp, 1'b0);
        end else if ((state_reg == ST_IDLE) && !accept) begin
            if (i_sp_load) begin
                sp_next = i_sp_load_value;
            end else if (i_push && !i_pull) begin
                sp_next = ivps_sp_step(o_sp, 1'b0);
            end else if (i_pull && !i_push) begin
                sp_next = ivps_sp_step(o_sp, 1'b1);
            end
        end
    end

    always @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 3'h0;
            vec_reg   <= `IVPS_VEC_RESERVED;
            frame_reg <= 40'h0;
        end else if (i_ce) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            vec_reg   <= vec_next;
            frame_reg <= frame_next;
        end
    end

    // full-width pointer: software may place the stack anywhere, it must keep it in ram
    always @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_sp <= `IVPS_SP_RESET;
        end else if (i_ce) begin
            o_sp <= sp_next;
        end
    end

    // each byte lands at the pointer value before its decrement
    always @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_mem_we    <= 1'b0;
            o_mem_addr  <= 16'h0000;
            o_mem_wdata <= 8'h00;
        end else if (i_ce) begin
            o_mem_we <= (state_reg == ST_STACK);
            if (state_reg == ST_STACK) begin
                o_mem_addr  <= o_sp;
                o_mem_wdata <= frame_reg[39:32];
            end
        end
    end

    // the block only strobes the vector addresses, the cpu reads the bytes itself
    always @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_vec_rd      <= 1'b0;
            o_vec_rd_addr <= 16'h0000;
        end else if (i_ce) begin
            o_vec_rd <= (state_reg == ST_VECHI) || (state_reg == ST_VECLO);
            if (state_reg == ST_VECHI) begin
                o_vec_rd_addr <= ivps_vec_byte(vec_reg, 1'b0);
            end else if (state_reg == ST_VECLO) begin
                o_vec_rd_addr <= ivps_vec_byte(vec_reg, 1'b1);
            end
        end
    end

    always @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_busy         <= 1'b0;
            o_done         <= 1'b0;
            o_taken_vector <= 16'h0000;
        end else if (i_ce) begin
            o_done <= (state_reg == ST_VECLO);
            if (accept) begin
                o_busy <= 1'b1;
            end else if (state_reg == ST_VECLO) begin
                o_busy         <= 1'b0;
                o_taken_vector <= vec_reg;
            end
        end
    end
endmodule // ivps_top

// File: tb/ivps_cpu_model.sv
// cpu side model: one take pulse per entry while armed and a request waits
`timescale 1ns/100ps
module ivps_cpu_model (
    input wire i_clk_sys, i_arm, i_pending, i_busy, i_done,
    output logic o_take
);
    initial o_take = 1'b0;
    // dropped after one cycle so a held level cannot start a second entry
    always @(posedge i_clk_sys) o_take <= i_arm && i_pending && !i_busy && !i_done && !o_take;
endmodule // ivps_cpu_model

// File: tb/ivps_top_chk.sv
// assertions on the ports of the vector priority and stacking block
`timescale 1ns/100ps
module ivps_top_chk (
    input wire i_clk_sys, i_reset, i_ce, i_software_interrupt, i_take, i_sp_load,
    input wire i_push, i_pull, o_irq_pending, o_mem_we, o_vec_rd, o_busy, o_done,
    input wire [15:0] o_vector_addr, o_sp, o_mem_addr
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    // take and load outrank push and pull, so those cycles are left out
    wire q = i_ce && !o_busy && !o_done && !i_sp_load && !(i_take && o_irq_pending);
    // run of enabled cycles; a frozen cycle stretches a frame and voids the count checks
    logic [3:0] ce_run;
    always @(posedge i_clk_sys or posedge i_reset)
        if (i_reset) ce_run <= 4'h0;
        else if (!i_ce) ce_run <= 4'h0;
        else if (ce_run != 4'hF) ce_run <= ce_run + 4'h1;
    sequence s_take; i_ce && i_take && o_irq_pending && !o_busy && !o_done; endsequence
    sequence s_frame;
        o_busy && !o_mem_we ##1 o_mem_we [*5] ##1 o_vec_rd ##1 o_vec_rd && o_done;
    endsequence
    a_entry_frame: assert property (disable iff (i_reset || !i_ce) s_take |=> s_frame)
        else $error("frame");
    a_vec_even: assert property (!o_vector_addr[0]) else $error("odd vector");
    a_swi_wins: assert property (i_software_interrupt |-> o_vector_addr == 16'hFFFC)
        else $error("swi lost");
    a_sp_reset: assert property ($fell(i_reset) |-> o_sp == 16'h00FF)
        else $error("sp reset");
    a_push_down: assert property (q && i_push && !i_pull |=> o_sp == $past(o_sp) - 16'h0001)
        else $error("push");
    a_pull_up: assert property (q && i_pull && !i_push |=> o_sp == $past(o_sp) + 16'h0001)
        else $error("pull");
    a_write_step: assert property (o_mem_we && $past(o_mem_we) && $past(i_ce) |->
        o_mem_addr == $past(o_mem_addr) - 16'h0001) else $error("write step");
    a_frame_sp: assert property ($rose(o_done) && ce_run >= 4'h8 |->
        o_sp == $past(o_sp, 8) - 16'h0005)
        else $error("frame size");
endmodule // ivps_top_chk
bind ivps_top ivps_top_chk u_chk (.*);

// File: tb/ivps_top_tb.sv
// self-checking bench for the vector priority and stacking block
`timescale 1ns/100ps
module ivps_top_tb;
    logic i_clk_sys = 0, i_reset = 1, i_irq_enable = 0, i_software_interrupt = 0, arm = 0;
    logic i_ce = 1, i_sp_load = 0, i_push = 0, i_pull = 0, i_take, o_irq_pending;
    logic o_mem_we, o_vec_rd;
    logic o_busy, o_done;
    logic [21:1] i_source_flag = 0, i_source_mask = 0;
    logic [15:0] i_pc = 0, i_sp_load_value = 0, msp = 16'h00FF, ev, o_vector_addr, o_sp;
    logic [15:0] o_mem_addr, o_vec_rd_addr, o_taken_vector;
    logic [7:0] i_acc = 0, i_index_low = 0, i_index_high = 0, i_ccr = 0, o_mem_wdata;
    logic [39:0] fr;
    logic [23:0] wq[$];
    logic [15:0] rq[$];
    integer bad_count = 0, n_tests = 0, seed = 6239, i;
    ivps_top uut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(i_ce),
        .i_source_flag(i_source_flag), .i_source_mask(i_source_mask),
        .i_irq_enable(i_irq_enable), .i_software_interrupt(i_software_interrupt),
        .i_take(i_take), .i_pc(i_pc), .i_acc(i_acc), .i_index_low(i_index_low),
        .i_index_high(i_index_high), .i_ccr(i_ccr), .i_sp_load(i_sp_load),
        .i_sp_load_value(i_sp_load_value), .i_push(i_push), .i_pull(i_pull),
        .o_irq_pending(o_irq_pending), .o_vector_addr(o_vector_addr), .o_sp(o_sp),
        .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
        .o_vec_rd(o_vec_rd), .o_vec_rd_addr(o_vec_rd_addr), .o_busy(o_busy),
        .o_done(o_done), .o_taken_vector(o_taken_vector));
    ivps_cpu_model cpu (.i_clk_sys, .i_arm(arm), .i_pending(o_irq_pending), .i_busy(o_busy),
        .i_done(o_done), .o_take(i_take));
    initial forever #25 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        if (o_mem_we === 1'b1) wq.push_back({o_mem_addr, o_mem_wdata});
        if (o_vec_rd === 1'b1) rq.push_back(o_vec_rd_addr);
    end
    task check(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task stop_test();
        $display("compares %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // reference: highest unmasked source wins, bottom pair when none waits
    function automatic logic [15:0] mvec();
        mvec = 16'hFFD0;
        for (int n = 21; n > 0; n--)
            if (i_irq_enable && i_source_flag[n] && !i_source_mask[n])
                mvec = 16'hFFFC - 16'(2 * n);
        if (i_software_interrupt) mvec = 16'hFFFC;
    endfunction
    // c low holds the clock enable off for the one cycle, so nothing may move
    task spop(input logic l, input logic u, input logic d, input logic [15:0] v, input logic c);
        @(posedge i_clk_sys);
        {i_ce, i_sp_load, i_push, i_pull, i_sp_load_value} <= {c, l, u, d, v};
        @(posedge i_clk_sys);
        {i_ce, i_sp_load, i_push, i_pull} <= 4'h8;
        msp = !c ? msp : l ? v : (u && !d) ? msp - 16'h0001 : (d && !u) ? msp + 16'h0001 : msp;
        #1 check(o_sp, msp);
    endtask
    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        spop(0, 0, 0, 16'h0000, 1);
        spop(1, 1, 0, 16'h0000, 1);
        spop(0, 1, 0, 16'h0000, 1);
        spop(0, 0, 1, 16'h0000, 1);
        spop(0, 1, 1, 16'h0000, 1);
        spop(0, 1, 0, 16'h0000, 0);
        spop(1, 0, 0, 16'h1234, 0);
        for (i = 0; i < 221; i++) begin
            @(posedge i_clk_sys);
            i_irq_enable <= i < 21 || i[0];
            i_software_interrupt <= i > 20 && i % 7 == 0;
            i_source_flag <= i < 21 ? 21'h1 << i : 21'($random(seed));
            i_source_mask <= i < 21 ? 21'h0 : 21'($random(seed));
            @(posedge i_clk_sys);
            #1 ev = mvec();
            check(o_vector_addr, ev);
            check(o_irq_pending, ev != 16'hFFD0);
        end
        for (i = 0; i < 20; i++) begin
            spop(1, 0, 0, 16'($random(seed)), 1);
            @(posedge i_clk_sys);
            {i_pc, i_acc, i_index_low, i_index_high, i_ccr} <= 48'({$random(seed), $random(seed)});
            i_source_flag <= 21'($random(seed)) | 21'h100000;
            i_source_mask <= 21'($random(seed)) & 21'h0FFFFF;
            i_irq_enable <= 1'b1;
            i_software_interrupt <= i[1:0] == 2'h0;
            arm <= 1'b1;
            @(posedge i_clk_sys);
            ev = mvec();
            wq.delete();
            rq.delete();
            for (int k = 0; k < 30 && o_done !== 1'b1; k++) @(posedge i_clk_sys);
            arm <= 1'b0;
            @(posedge i_clk_sys);
            #1 fr = {i_pc[7:0], i_pc[15:8], i_index_low, i_acc, i_ccr};
            check(wq.size() * 2 + rq.size(), 24'd12);
            for (int k = 0; k < 5; k++)
                check(wq[k], {msp - 16'(k), fr[39 - 8 * k -: 8]});
            check(rq[0], ev);
            check(rq[1], ev | 16'h0001);
            check(o_taken_vector, ev);
            msp = msp - 16'h0005;
            check(o_sp, msp);
        end
        stop_test();
    end
    initial begin
        #1000000;
        bad_count++;
        stop_test();
    end
endmodule // ivps_top_tb
